/* common/arb_regs.svh */
`ifndef ARB_REGS_SVH
`define ARB_REGS_SVH

// bus control register bit that turns on debug idle injection
`define ARB_CTL_DEBUG_BIT   12
// idle cycles injected between transactions in debug mode
`define ARB_DEBUG_GAP       2'h2
// idle cycles inserted after a run of back-to-back transactions
`define ARB_FAIR_GAP        2'h1
// back-to-back transactions allowed before a fair idle cycle
`define ARB_B2B_LIMIT       3'h5
// reset value of the back-to-back counter
`define ARB_B2B_RESET       3'h0

`endif

/* common/arb_pkg.sv */
package arb_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_OWN  = 2'b01,
    ST_GAP  = 2'b10
  } arb_state_t;

  typedef enum logic {
    TYPE_PROC = 1'b0,
    TYPE_IO   = 1'b1
  } node_type_t;

endpackage

/* core/rr_pick.sv */
// round-robin picker: first requester above the last selected index, wrapping
module rr_pick #(
  parameter int N  = 4,
  parameter int IW = 2
) (
  input  wire logic [N-1:0]  req_i,
  input  wire logic [IW-1:0] last_i,
  output logic               any_o,
  output logic [IW-1:0]      idx_o
);

  int cand;

  always_comb begin
    cand  = 0;
    any_o = 1'b0;
    idx_o = '0;
    for (int k = 1; k <= N; k++) begin
      cand = (int'(last_i) + k) % N;
      if (!any_o && req_i[cand]) begin
        any_o = 1'b1;
        idx_o = IW'(cand);
      end
    end
  end

endmodule // rr_pick

/* core/bus_arbiter.sv */
`include "arb_regs.svh"

module bus_arbiter #(
  parameter int NP = 4,
  parameter int NI = 2
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic [NP-1:0]          processor_bus_request_i,
  input  wire logic [NI-1:0]          io_bus_request_i,
  input  wire logic                   txn_done_i,
  input  wire logic [31:0]            bus_control_register_i,
  input  wire arb_pkg::node_type_t    unused_type_i,
  output logic [NP+NI-1:0]            grant_o,
  output logic                        idle_insert_o,
  output logic                        exclusive_o
);

  import arb_pkg::*;

  localparam int NN  = NP + NI;
  localparam int PW  = $clog2(NP);
  localparam int IOW = $clog2(NI);

  // request synchronisers; remote processors pass one more stage
  logic [NP-1:0]  proc_meta_q;
  logic [NP-1:0]  proc_sync_q;
  logic [NP-1:0]  proc_late_q;
  logic [NI-1:0]  io_meta_q;
  logic [NI-1:0]  io_sync_q;

  // arbitration state
  arb_state_t     state_q;
  arb_state_t     state_d;
  logic [NN-1:0]  owner_q;
  logic [NN-1:0]  owner_d;
  logic [NN-1:0]  grant_q;
  logic [NN-1:0]  grant_d;
  logic [PW-1:0]  last_proc_q;
  logic [PW-1:0]  last_proc_d;
  logic [IOW-1:0] last_io_q;
  logic [IOW-1:0] last_io_d;
  node_type_t     last_type_q;
  node_type_t     last_type_d;
  logic           bias_q;
  logic           bias_d;
  logic           held_q;
  logic           held_d;
  logic [2:0]     b2b_q;
  logic [2:0]     b2b_d;
  logic [1:0]     gap_q;
  logic [1:0]     gap_d;
  logic           idle_q;
  logic           excl_q;

  // decoded requests and picks
  logic [NP-1:0]  proc_req;
  logic [NI-1:0]  io_req;
  logic [NN-1:0]  all_req;
  logic           proc_any;
  logic           io_any;
  logic [PW-1:0]  proc_idx;
  logic [IOW-1:0] io_idx;
  logic           any_req;
  logic           owner_req;
  logic           owner_is_io;
  logic           excl;
  logic           choose_io;
  logic           debug_idle;
  logic           fair_due;
  logic [NN-1:0]  pick_onehot;
  logic [NN-1:0]  next_owner;

  function automatic logic [NN-1:0] proc_hot(input logic [PW-1:0] idx);
    logic [NN-1:0] v;
    v      = '0;
    v[idx] = 1'b1;
    return v;
  endfunction

  function automatic logic [NN-1:0] io_hot(input logic [IOW-1:0] idx);
    logic [NN-1:0] v;
    v           = '0;
    v[NP + idx] = 1'b1;
    return v;
  endfunction

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      proc_meta_q <= '0;
      proc_sync_q <= '0;
      proc_late_q <= '0;
      io_meta_q   <= '0;
      io_sync_q   <= '0;
    end else begin
      proc_meta_q <= processor_bus_request_i;
      proc_sync_q <= proc_meta_q;
      proc_late_q <= proc_sync_q;
      io_meta_q   <= io_bus_request_i;
      io_sync_q   <= io_meta_q;
    end
  end

  // local processor zero skips the extra stage of the remote ones
  assign proc_req = {proc_late_q[NP-1:1], proc_sync_q[0]};
  assign io_req   = io_sync_q;
  assign all_req  = {io_req, proc_req};

  rr_pick #(
    .N  (NP),
    .IW (PW)
  ) u_proc_pick (
    .req_i  (proc_req),
    .last_i (last_proc_q),
    .any_o  (proc_any),
    .idx_o  (proc_idx)
  );

  rr_pick #(
    .N  (NI),
    .IW (IOW)
  ) u_io_pick (
    .req_i  (io_req),
    .last_i (last_io_q),
    .any_o  (io_any),
    .idx_o  (io_idx)
  );

  assign any_req     = proc_any | io_any;
  assign owner_req   = |(owner_q & all_req);
  assign owner_is_io = |owner_q[NN-1:NP];
  // only an I/O owner that never dropped its request keeps the bus
  assign excl        = owner_is_io & held_q & owner_req;
  assign debug_idle  = bus_control_register_i[`ARB_CTL_DEBUG_BIT];
  assign fair_due    = (b2b_q == `ARB_B2B_LIMIT);

  // type selection: bias after idle, else alternate, else stay in one type
  assign choose_io = !proc_any ? io_any :
                     !io_any   ? 1'b0   :
                     bias_q    ? 1'b0   :
                     (last_type_q == TYPE_PROC);

  assign pick_onehot = choose_io ? io_hot(io_idx) : proc_hot(proc_idx);
  assign next_owner  = excl ? owner_q : pick_onehot;

  // next winner is prepared every cycle, in parallel with the transfer
  always_comb begin
    state_d     = state_q;
    owner_d     = owner_q;
    grant_d     = '0;
    last_proc_d = last_proc_q;
    last_io_d   = last_io_q;
    last_type_d = last_type_q;
    bias_d      = bias_q;
    held_d      = held_q & owner_req;
    b2b_d       = b2b_q;
    gap_d       = gap_q;
    case (state_q)
      ST_IDLE: begin
        held_d = 1'b0;
        b2b_d  = `ARB_B2B_RESET;
        if (any_req || excl) begin
          state_d = ST_OWN;
          owner_d = next_owner;
          grant_d = next_owner;
          held_d  = 1'b1;
          b2b_d   = 3'h1;
          bias_d  = 1'b0;
        end else begin
          bias_d  = 1'b1;
        end
      end
      ST_OWN: begin
        grant_d = grant_q;
        if (txn_done_i) begin
          grant_d = '0;
          if (debug_idle) begin
            state_d = ST_GAP;
            gap_d   = `ARB_DEBUG_GAP;
            b2b_d   = `ARB_B2B_RESET;
          end else if (fair_due && (any_req || excl)) begin
            state_d = ST_GAP;
            gap_d   = `ARB_FAIR_GAP;
            b2b_d   = `ARB_B2B_RESET;
          end else if (any_req || excl) begin
            // a lone node that dropped and re-raised wins again here
            owner_d = next_owner;
            grant_d = next_owner;
            held_d  = excl | ~(|(next_owner & owner_q));
            b2b_d   = b2b_q + 3'h1;
          end else begin
            state_d = ST_IDLE;
            b2b_d   = `ARB_B2B_RESET;
          end
        end
      end
      ST_GAP: begin
        gap_d = gap_q - 2'h1;
        if (gap_q == 2'h1) begin
          if (any_req || excl) begin
            state_d = ST_OWN;
            owner_d = next_owner;
            grant_d = next_owner;
            held_d  = excl | ~(|(next_owner & owner_q));
            b2b_d   = 3'h1;
          end else begin
            state_d = ST_IDLE;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
        owner_d = '0;
        held_d  = 1'b0;
        gap_d   = 2'h0;
        b2b_d   = `ARB_B2B_RESET;
      end
    endcase
    // rotation pointers follow every fresh non-exclusive grant
    if ((grant_d != '0) && (grant_d != grant_q || state_q != ST_OWN) && !excl) begin
      if (choose_io) begin
        last_io_d   = io_idx;
        last_type_d = TYPE_IO;
      end else begin
        last_proc_d = proc_idx;
        last_type_d = TYPE_PROC;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q     <= ST_IDLE;
      owner_q     <= '0;
      grant_q     <= '0;
      last_proc_q <= PW'(NP - 1);
      last_io_q   <= IOW'(NI - 1);
      last_type_q <= TYPE_IO;
      bias_q      <= 1'b1;
      held_q      <= 1'b0;
      b2b_q       <= `ARB_B2B_RESET;
      gap_q       <= 2'h0;
    end else begin
      state_q     <= state_d;
      owner_q     <= owner_d;
      grant_q     <= grant_d;
      last_proc_q <= last_proc_d;
      last_io_q   <= last_io_d;
      last_type_q <= last_type_d;
      bias_q      <= bias_d;
      held_q      <= held_d;
      b2b_q       <= b2b_d;
      gap_q       <= gap_d;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      idle_q <= 1'b0;
      excl_q <= 1'b0;
    end else begin
      idle_q <= (state_d == ST_GAP);
      excl_q <= (state_d == ST_OWN) & held_d & (|owner_d[NN-1:NP]);
    end
  end

  assign grant_o       = grant_q;
  assign idle_insert_o = idle_q;
  assign exclusive_o   = excl_q;

endmodule // bus_arbiter

/* verification/bus_arbiter_props.sv */
module bus_arbiter_props #(
  parameter int NP = 4,
  parameter int NI = 2
) (
  input wire logic                clk_i,
  input wire logic                rst_i,
  input wire logic [NP-1:0]       processor_bus_request_i,
  input wire logic [NI-1:0]       io_bus_request_i,
  input wire logic                txn_done_i,
  input wire logic [31:0]         bus_control_register_i,
  input wire arb_pkg::node_type_t unused_type_i,
  input wire logic [NP+NI-1:0]    grant_o,
  input wire logic                idle_insert_o,
  input wire logic                exclusive_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import arb_pkg::*;
  logic quiet;
  // nothing else pending, so a lone request sees the bare latency
  assign quiet = (grant_o == '0) && !idle_insert_o;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_grant_onehot: assert property ($onehot0(grant_o))
    else $error("more than one grant");
  a_grant_holds: assert property (|grant_o && !txn_done_i |=> $stable(grant_o))
    else $error("grant moved mid transaction");
  a_gap_no_grant: assert property (idle_insert_o |-> grant_o == '0)
    else $error("grant during idle cycle");
  a_fair_single: assert property (!bus_control_register_i[12] && $rose(idle_insert_o) |=> !idle_insert_o && |grant_o)
    else $error("fair gap not one cycle");
  a_debug_two: assert property (bus_control_register_i[12] && $rose(idle_insert_o) |-> ##1 idle_insert_o ##1 !idle_insert_o)
    else $error("debug gap not two cycles");
  a_excl_io_only: assert property (exclusive_o |-> grant_o[NP+NI-1:NP] != '0)
    else $error("exclusive without io owner");
  a_io_latency: assert property ($rose(io_bus_request_i[0]) && quiet && processor_bus_request_i == '0 |-> ##3 grant_o[NP])
    else $error("io grant latency");
  a_p0_latency: assert property ($rose(processor_bus_request_i[0]) && quiet && io_bus_request_i == '0 && processor_bus_request_i[NP-1:1] == '0 |-> ##[3:4] grant_o[0])
    else $error("processor zero latency");
  a_p1_latency: assert property ($rose(processor_bus_request_i[1]) && quiet && io_bus_request_i == '0 && processor_bus_request_i == 4'h2 |-> ##[4:5] grant_o[1])
    else $error("processor one latency");
endmodule // bus_arbiter_props

/* verification/commander_model.sv */
module commander_model #(
  parameter int LEN = 6
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [5:0] grant_i,
  input  wire logic [5:0] want_i,
  input  wire logic [5:0] excl_i,
  output logic      [3:0] proc_req_o,
  output logic      [1:0] io_req_o,
  output logic            txn_done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_q;
  logic [5:0] drop_q;
  assign txn_done_o = (grant_i != '0) && (cnt_q == 8'(LEN - 1));
  // exclusive owners never drop; others drop for one cycle early in each own transfer,
  // so the arbiter sees the drop through its synchronisers before the transfer ends
  assign {io_req_o, proc_req_o} = want_i & ~drop_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      drop_q <= '0;
    end else begin
      cnt_q <= (txn_done_o || grant_i == '0) ? 8'h00 : cnt_q + 8'h01;
      drop_q <= (grant_i != '0 && cnt_q == 8'h00) ? (grant_i & ~excl_i) : 6'h00;
    end
  end
endmodule // commander_model

/* verification/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import arb_pkg::*;
  logic clk_i = 0, rst_i = 1, done, gap, ex;
  logic [31:0] ctl = 0;
  logic [5:0] want = 0, excl = 0, gnt, pg;
  logic [3:0] preq;
  logic [1:0] ioreq;
  logic pd;
  int mismatches = 0, tests_run = 0, gaps, holes, exs;
  logic [5:0] gq[$];
  initial forever #2.5 clk_i = ~clk_i;
  commander_model #(.LEN(6)) u_cmd (.clk_i(clk_i), .rst_i(rst_i), .grant_i(gnt),
    .want_i(want), .excl_i(excl), .proc_req_o(preq), .io_req_o(ioreq), .txn_done_o(done));
  bus_arbiter uut (.clk_i(clk_i), .rst_i(rst_i), .processor_bus_request_i(preq),
    .io_bus_request_i(ioreq), .txn_done_i(done), .bus_control_register_i(ctl),
    .unused_type_i(TYPE_PROC), .grant_o(gnt), .idle_insert_o(gap), .exclusive_o(ex));
  // log each new grant, forced idle cycles and holes after the first grant
  always @(posedge clk_i) begin
    if (!rst_i && gnt != 0 && (gnt != pg || pd)) gq.push_back(gnt);
    if (!rst_i && gap) gaps++;
    if (!rst_i && ex) exs++;
    if (!rst_i && gnt == 0 && gq.size() > 0) holes++;
    pg = gnt;
    pd = done;
  end
  task chk(input string n, input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %s expected %0h seen %0h", n, exp, got);
    end
  endtask
  task end_sim;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task restart(input logic [5:0] w, input logic [5:0] x, input logic dbg);
    @(posedge clk_i);
    #1 rst_i = 1;
    want = 0;
    excl = x;
    ctl = {19'h0, dbg, 12'h0};
    repeat (8) @(posedge clk_i);
    chk("reset outputs", {gap, ex, gnt}, 8'h00);
    #1 rst_i = 0;
    gq.delete();
    gaps = 0;
    holes = 0;
    exs = 0;
    want = w;
  endtask
  task wait_g(input int n);
    for (int i = 0; i < 3000 && gq.size() < n; i++) begin
      @(posedge clk_i);
      #1;
    end
    if (gq.size() < n) begin
      chk("grant timeout", 8'h00, 8'h01);
      end_sim;
    end
  endtask
  task exp_seq(input int n, input logic [5:0] e[6]);
    for (int i = 0; i < n; i++) chk("grant order", 8'(gq[i]), 8'(e[i]));
  endtask
  task s_all;
    restart(6'h3F, 6'h00, 1'b0);
    wait_g(6);
    exp_seq(6, '{6'h01, 6'h10, 6'h02, 6'h20, 6'h04, 6'h10});
    chk("fair gaps", 8'(gaps), 8'h01);
    chk("saturated holes", 8'(holes), 8'h01);
  endtask
  task s_one_type;
    restart(6'h0F, 6'h00, 1'b0);
    wait_g(4);
    exp_seq(4, '{6'h01, 6'h02, 6'h04, 6'h08, 6'h00, 6'h00});
    restart(6'h31, 6'h00, 1'b0);
    wait_g(4);
    exp_seq(4, '{6'h01, 6'h10, 6'h01, 6'h20, 6'h00, 6'h00});
  endtask
  task s_b2b;
    restart(6'h02, 6'h00, 1'b0);
    wait_g(3);
    exp_seq(3, '{6'h02, 6'h02, 6'h02, 6'h00, 6'h00, 6'h00});
    chk("idle holes", 8'(holes), 8'h00);
  endtask
  task s_excl;
    restart(6'h12, 6'h10, 1'b0);
    wait_g(6);
    exp_seq(6, '{6'h10, 6'h10, 6'h10, 6'h10, 6'h10, 6'h10});
    chk("exclusive seen", 8'(exs != 0), 8'h01);
    chk("exclusive now", 8'(ex), 8'h01);
    want = 6'h02;
    wait_g(gq.size() + 3);
    chk("after release", 8'(gq[$]), 8'h02);
    chk("exclusive released", 8'(ex), 8'h00);
    restart(6'h05, 6'h01, 1'b0);
    wait_g(2);
    exp_seq(2, '{6'h01, 6'h04, 6'h00, 6'h00, 6'h00, 6'h00});
  endtask
  task s_dbg;
    restart(6'h3F, 6'h00, 1'b1);
    wait_g(3);
    chk("debug gaps", 8'(gaps), 8'h04);
  endtask
  task lat(input int k, input int lo, input int hi);
    int n;
    restart(6'(1 << k), 6'h00, 1'b0);
    n = 0;
    while (n < 20 && gnt[k] !== 1'b1) begin
      @(posedge clk_i);
      #1 n++;
    end
    chk("latency", 8'(n >= lo && n <= hi), 8'h01);
  endtask
  initial begin
    s_all();
    s_one_type();
    s_b2b();
    s_excl();
    s_dbg();
    lat(4, 3, 3);
    lat(5, 3, 3);
    lat(0, 3, 4);
    lat(1, 4, 5);
    lat(3, 4, 5);
    end_sim();
  end
endmodule // testbench
bind bus_arbiter bus_arbiter_props #(.NP(NP), .NI(NI)) u_props (.clk_i(clk_i), .rst_i(rst_i),
  .processor_bus_request_i(processor_bus_request_i), .io_bus_request_i(io_bus_request_i),
  .txn_done_i(txn_done_i), .bus_control_register_i(bus_control_register_i),
  .unused_type_i(unused_type_i), .grant_o(grant_o), .idle_insert_o(idle_insert_o),
  .exclusive_o(exclusive_o));
